/* File: core/stat_pkg.sv */
// Purpose: shared constants and types for the status enable and recall block
// Assumes: one 100 MHz clock, AHB-Lite register access, 32-bit data
// Notes: offsets are byte addresses decoded on haddr[7:0]
package stat_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_PRE_MASK = 8'h04;
  localparam logic [7:0] ADDR_PSC_FLAG = 8'h08;
  localparam logic [7:0] ADDR_IST = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_ERR = 8'h14;
  localparam logic [7:0] ADDR_CONFIG = 8'h18;
  localparam logic [7:0] ADDR_ENABLES = 8'h1c;

  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_ARG_LSB = 8;

  // command opcodes
  localparam logic [3:0] OP_SET_POLL = 4'h1;
  localparam logic [3:0] OP_SET_PSC = 4'h2;
  localparam logic [3:0] OP_RECALL = 4'h3;
  localparam logic [3:0] OP_RESET = 4'h4;
  localparam logic [3:0] OP_SAVE = 4'h5;

  // status register fields
  localparam int STATUS_BUSY_BIT = 8;
  localparam int STATUS_ERR_BIT = 9;

  // configuration bins
  localparam logic [2:0] PERSIST_SLOT = 3'h0;
  localparam logic [7:0] BIN_FACTORY = 8'h00;
  localparam logic [7:0] BIN_LAST = 8'h04;
  localparam int NV_DEPTH = 8;

  // configuration word
  localparam int CFG_W = 24;
  localparam int CFG_OUT_BIT = 0;
  localparam logic [23:0] FACTORY_CFG = 24'h000000;
  localparam int ENA_W = 16;

  // reset values
  localparam logic [7:0] RESET_MASK = 8'h00;
  localparam logic RESET_PSC = 1'b1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_APPLY = 2'b11,
    ST_BOOT = 2'b10
  } state_t;

  typedef struct packed {
    logic [3:0] op;
    logic [7:0] arg;
  } cmd_t;

  // one word of the non-volatile store
  typedef struct packed {
    logic valid;
    logic psc;
    logic [5:0] pad;
    logic [23:0] data;
  } nv_word_t;

  typedef struct packed {
    logic [2:0] addr;
    logic we;
    logic erase;
    nv_word_t wdata;
  } nv_req_t;

  typedef struct packed {
    state_t st;
    logic [7:0] mask;
    logic psc;
    logic [23:0] cfg;
    logic [15:0] ena;
    logic err;
    logic [2:0] bin;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } regs_t;

endpackage

/* File: core/nv_store.sv */
// Purpose: non-volatile store for saved bins and the power-off enable image
// Assumes: contents survive reset; valid flags are cleared by erase, or one at a time by a write with wdata.valid low
// Notes: read data registered, one cycle after the address
`timescale 1ns/1ps
module nv_store (
  input wire logic mclk_i,
  input wire stat_pkg::nv_req_t req_i,
  output stat_pkg::nv_word_t rdata_o
);

  stat_pkg::nv_word_t mem [stat_pkg::NV_DEPTH];
  logic [stat_pkg::NV_DEPTH-1:0] valid;
  stat_pkg::nv_word_t rd;

  // no reset on purpose: this models storage that outlives power-down
  always_ff @(posedge mclk_i) begin
    if (req_i.erase) begin
      valid <= '0;
    end else if (req_i.we) begin
      valid[req_i.addr] <= req_i.wdata.valid;
    end
    if (req_i.we) begin
      mem[req_i.addr] <= req_i.wdata;
    end
    rd <= mem[req_i.addr];
    rd.valid <= valid[req_i.addr] & ~req_i.erase;
  end

  assign rdata_o = rd;

endmodule

/* File: core/poll_status.sv */
// Purpose: individual status bit from poll enable mask and status byte
// Assumes: status byte comes from logic on the same clock
// Notes: result registered, one cycle behind its inputs
`timescale 1ns/1ps
module poll_status (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] mask_i,
  input wire logic [7:0] stb_i,
  output logic ist_o
);

  logic ist;

  // recomputed every cycle so any change of mask or status shows next cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ist <= 1'b0;
    end else begin
      ist <= |(mask_i & stb_i); // [RQ2] [RQ14]
    end
  end

  assign ist_o = ist;

endmodule

/* File: core/stat_cmd.sv */
// Purpose: status enable, power-on clear and configuration recall commands
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes: commands are written to the command register; results read back
//
// How it works
// [RQ1] set-poll command replaces the eight-bit poll enable mask with its argument
// [RQ2] individual status is one when mask AND status byte has any bit set
// [RQ3] poll mask register reads back the current mask contents
// [RQ4] power-on clear flag one: enable registers come up cleared
// [RQ5] power-on clear flag zero: enable registers reload their power-off value
// [RQ6] power-on clear flag reads back as zero or one
// [RQ7] recall loads the whole configuration from the chosen saved bin
// [RQ8] recall of bin zero sets the same factory configuration as the reset command, but never erases the store
// [RQ9] recall of an empty bin keeps configuration and raises the error flag
// [RQ10] only bins zero to four are valid; one to four hold saved images
// [RQ11] reset restores factory configuration with output off, remote kept
// [RQ12] individual status reads as a single bit, zero false, one true
// [RQ13] poll enable mask is eight bits, one per status byte bit
// [RQ14] individual status follows mask and status byte changes every cycle
`timescale 1ns/1ps
module stat_cmd (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [7:0] stb_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic ist_o,
  output logic [23:0] config_o,
  output logic [15:0] enables_o,
  output logic error_o
);

  stat_pkg::regs_t r;
  stat_pkg::regs_t next_r;
  stat_pkg::nv_req_t nv_req;
  stat_pkg::nv_word_t nv_rd;
  stat_pkg::cmd_t cmd;
  logic ist;
  logic addr_take;
  logic err_set;
  logic err_clr;
  logic busy;
  logic bin_zero;
  logic bin_saved;
  logic flag_ok;

  nv_store nv_store_inst (
    .mclk_i(mclk_i),
    .req_i(nv_req),
    .rdata_o(nv_rd)
  );

  poll_status poll_status_inst (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .mask_i(r.mask),
    .stb_i(stb_i),
    .ist_o(ist)
  );

  // read data are captured in the address phase, so reads never wait
  function automatic logic [31:0] read_mux(input logic [7:0] a, input stat_pkg::regs_t s,
                                           input logic ist_v, input logic [7:0] stb_v);
    logic [31:0] d;
    d = 32'h00000000;
    case (a)
      // command register is write-only; reading it gives zero
      stat_pkg::ADDR_CMD: begin
        d = 32'h00000000;
      end
      stat_pkg::ADDR_PRE_MASK: begin
        d[7:0] = s.mask; // [RQ3] [RQ13]
      end
      stat_pkg::ADDR_PSC_FLAG: begin
        d[0] = s.psc; // [RQ6]
      end
      stat_pkg::ADDR_IST: begin
        d[0] = ist_v; // [RQ12]
      end
      stat_pkg::ADDR_STATUS: begin
        d[7:0] = stb_v;
        d[stat_pkg::STATUS_BUSY_BIT] = (s.st != stat_pkg::ST_IDLE);
        d[stat_pkg::STATUS_ERR_BIT] = s.err;
      end
      stat_pkg::ADDR_ERR: begin
        d[0] = s.err;
      end
      stat_pkg::ADDR_CONFIG: begin
        d[23:0] = s.cfg;
      end
      stat_pkg::ADDR_ENABLES: begin
        d[15:0] = s.ena;
      end
      default: begin
        d = 32'h00000000;
      end
    endcase
    return d;
  endfunction

  assign addr_take = hsel_i & hready_i & htrans_i[1];
  assign cmd.op = hwdata_i[stat_pkg::CMD_OP_LSB +: 4];
  assign cmd.arg = hwdata_i[stat_pkg::CMD_ARG_LSB +: 8];

  // decoded once so the command case below stays flat
  assign busy = (r.st != stat_pkg::ST_IDLE);
  assign bin_zero = (cmd.arg == stat_pkg::BIN_FACTORY);
  assign bin_saved = ~bin_zero & (cmd.arg <= stat_pkg::BIN_LAST); // [RQ10]
  assign flag_ok = (cmd.arg <= 8'h01);

  always_comb begin
    next_r = r;
    err_set = 1'b0;
    err_clr = 1'b0;
    nv_req.addr = stat_pkg::PERSIST_SLOT;
    nv_req.we = 1'b0;
    nv_req.erase = 1'b0;
    nv_req.wdata = '0;

    // bus address phase
    if (addr_take) begin
      next_r.dph_wr = hwrite_i;
      next_r.dph_addr = haddr_i[7:0];
      if (!hwrite_i) begin
        next_r.rdata = read_mux(haddr_i[7:0], r, ist, stb_i);
      end
    end else begin
      next_r.dph_wr = 1'b0;
    end

    // sequencer
    case (r.st)
      stat_pkg::ST_BOOT: begin
        nv_req.addr = stat_pkg::PERSIST_SLOT;
        next_r.bin = stat_pkg::PERSIST_SLOT;
        next_r.st = stat_pkg::ST_APPLY;
      end
      stat_pkg::ST_READ: begin
        nv_req.addr = r.bin;
        next_r.st = stat_pkg::ST_APPLY;
      end
      stat_pkg::ST_APPLY: begin
        if (r.bin == stat_pkg::PERSIST_SLOT) begin
          // no image yet (first power-up or just erased): keep the reset values
          if (nv_rd.valid) begin
            next_r.psc = nv_rd.psc;
            if (nv_rd.psc) begin
              next_r.ena = '0; // [RQ4]
            end else begin
              next_r.ena = nv_rd.data[stat_pkg::ENA_W-1:0]; // [RQ5]
            end
          end
        end else if (nv_rd.valid) begin
          next_r.cfg = nv_rd.data; // [RQ7]
        end else begin
          err_set = 1'b1; // [RQ9]
        end
        next_r.st = stat_pkg::ST_IDLE;
      end
      stat_pkg::ST_IDLE: begin
        // mirror the enable image so it holds the power-off value
        nv_req.we = 1'b1; // [RQ5]
        nv_req.addr = stat_pkg::PERSIST_SLOT;
        nv_req.wdata.valid = 1'b1;
        nv_req.wdata.psc = r.psc;
        nv_req.wdata.data = {8'h00, r.ena};
      end
      default: begin
        next_r.st = stat_pkg::ST_IDLE;
      end
    endcase

    // bus data phase of a write
    if (r.dph_wr) begin
      case (r.dph_addr)
        stat_pkg::ADDR_CMD: begin
          if (busy) begin
            err_set = 1'b1;
          end else begin
            case (cmd.op)
              stat_pkg::OP_SET_POLL: begin
                next_r.mask = cmd.arg; // [RQ1] [RQ13]
              end
              stat_pkg::OP_SET_PSC: begin
                if (!flag_ok) begin
                  err_set = 1'b1;
                end else begin
                  next_r.psc = cmd.arg[0]; // [RQ6]
                end
              end
              stat_pkg::OP_RECALL: begin
                if (bin_zero) begin
                  next_r.cfg = stat_pkg::FACTORY_CFG; // [RQ8] [RQ11]
                  next_r.cfg[stat_pkg::CFG_OUT_BIT] = 1'b0; // [RQ11]
                end else if (bin_saved) begin
                  next_r.bin = cmd.arg[2:0]; // [RQ10]
                  next_r.st = stat_pkg::ST_READ; // [RQ7]
                end else begin
                  err_set = 1'b1; // [RQ10]
                end
              end
              stat_pkg::OP_RESET: begin
                next_r.cfg = stat_pkg::FACTORY_CFG; // [RQ11]
                next_r.cfg[stat_pkg::CFG_OUT_BIT] = 1'b0; // [RQ11]
                nv_req.erase = cmd.arg[0];
              end
              stat_pkg::OP_SAVE: begin
                if (bin_saved) begin
                  nv_req.we = 1'b1; // [RQ10]
                  nv_req.addr = cmd.arg[2:0];
                  nv_req.wdata.valid = 1'b1;
                  nv_req.wdata.psc = 1'b0;
                  nv_req.wdata.data = r.cfg;
                end else begin
                  err_set = 1'b1;
                end
              end
              default: begin
                err_set = 1'b1;
              end
            endcase
          end
        end
        stat_pkg::ADDR_ERR: begin
          err_clr = hwdata_i[0];
        end
        stat_pkg::ADDR_CONFIG: begin
          next_r.cfg = hwdata_i[stat_pkg::CFG_W-1:0];
        end
        stat_pkg::ADDR_ENABLES: begin
          next_r.ena = hwdata_i[stat_pkg::ENA_W-1:0];
        end
        default: begin
          next_r.err = r.err;
        end
      endcase
    end

    // a new error in the clearing cycle is kept
    next_r.err = (r.err & ~err_clr) | err_set;
    next_r.ready = 1'b1;
    next_r.resp = 1'b0;
  end

  // power-up walks through the boot read before taking commands
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      r.st <= stat_pkg::ST_BOOT;
      r.mask <= stat_pkg::RESET_MASK;
      r.psc <= stat_pkg::RESET_PSC;
      r.cfg <= stat_pkg::FACTORY_CFG;
      r.ena <= '0;
      r.err <= 1'b0;
      r.bin <= stat_pkg::PERSIST_SLOT;
      r.dph_wr <= 1'b0;
      r.dph_addr <= 8'h00;
      r.rdata <= 32'h00000000;
      r.ready <= 1'b1;
      r.resp <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign hrdata_o = r.rdata;
  assign hreadyout_o = r.ready;
  assign hresp_o = r.resp;
  assign ist_o = ist;
  assign config_o = r.cfg;
  assign enables_o = r.ena;
  assign error_o = r.err;

endmodule

/* File: verif/stat_cmd_monitor.sv */
// Purpose: port checker for stat_cmd
// Assumes: no command is sent while busy or restoring
// Notes: mask copy rebuilt from bus writes, so refused writes would desync it
`timescale 1ns/1ps
module stat_cmd_monitor (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [7:0] stb_i,
  input wire logic ist_o,
  input wire logic [23:0] config_o,
  input wire logic error_o
);
  logic aph, awr;
  logic [7:0] aad, m;
  wire cmd = aph && awr && aad == stat_pkg::ADDR_CMD;
  wire [3:0] op = hwdata_i[3:0];
  wire [7:0] arg = hwdata_i[15:8];
  wire rcl = cmd && op == stat_pkg::OP_RECALL;
  always_ff @(posedge mclk_i) begin
    aph <= !rst_i && hsel_i && hready_i && htrans_i[1];
    awr <= hwrite_i;
    aad <= haddr_i[7:0];
    if (rst_i) m <= 8'h00;
    else if (cmd && op == stat_pkg::OP_SET_POLL) m <= arg;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  AST_IST_EQ: assert property (ist_o == |($past(stb_i) & $past(m)))
    else $error("ist differs from mask and status");
  AST_IST_FOLLOW: assert property ($changed(stb_i) && (stb_i & m) != 8'h00 |=> ist_o)
    else $error("ist missed a status change");
  AST_IST_SRC: assert property (ist_o |-> $past(stb_i) != 8'h00)
    else $error("ist true with empty status");
  AST_RESET_CFG: assert property (cmd && op == stat_pkg::OP_RESET
    |=> config_o == stat_pkg::FACTORY_CFG || error_o) else $error("reset kept config");
  AST_RCL0: assert property (rcl && arg == stat_pkg::BIN_FACTORY
    |=> config_o == stat_pkg::FACTORY_CFG || error_o) else $error("bin zero not factory");
  AST_BIN_RANGE: assert property (rcl && arg > stat_pkg::BIN_LAST |=> error_o)
    else $error("bad bin not flagged");
  AST_RCL_EMPTY: assert property (rcl && arg != 8'h00 && arg <= 8'h04
    ##3 $rose(error_o) |-> $stable(config_o)) else $error("empty bin changed config");
  AST_RCL_HOLD: assert property (rcl && arg != 8'h00 && arg <= 8'h04
    |=> $stable(config_o)) else $error("config moved before load");
endmodule
bind stat_cmd stat_cmd_monitor stat_cmd_monitor_inst (.mclk_i(mclk_i), .rst_i(rst_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hwdata_i(hwdata_i), .hready_i(hready_i), .stb_i(stb_i), .ist_o(ist_o),
  .config_o(config_o), .error_o(error_o));

/* File: verif/ahb_host.sv */
// Purpose: host model issuing single AHB-Lite word transfers
// Assumes: one slave, response always OKAY
// Notes: hung_o marks a wait that ran out; idle data is inverted, not held
`timescale 1ns/1ps
module ahb_host (
  input wire logic mclk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [31:0] hwdata_o,
  output logic hung_o
);
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h00000000;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hwdata_o = 32'h00000000;
    hung_o = 1'b0;
  end
  task automatic wt();
    int n;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (!hready_i && n < 16);
    if (!hready_i) hung_o = 1'b1;
  endtask
  // called right after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    hsel_o <= 1'b1;
    haddr_o <= {24'h000000, a};
    htrans_o <= 2'b10;
    hwrite_o <= w;
    hwdata_o <= ~hwdata_o;
    wt();
    hsel_o <= 1'b0;
    htrans_o <= 2'b00;
    hwdata_o <= d;
    wt();
    r = hrdata_i;
  endtask
endmodule

/* File: verif/status_enable_and_recall_cmds_test.sv */
// Purpose: self-checking bench for stat_cmd
// Assumes: zero wait slave, store erased by the first reset command
// Notes: status bytes and all masks after the first two (00, ff) come from an lfsr seeded with 7
`timescale 1ns/1ps
module status_enable_and_recall_cmds_test;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] stb = 8'h00;
  logic hsel, hwrite, hready, hresp, ist, err, hung;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [23:0] cfg;
  logic [15:0] ena;
  logic [7:0] s = 8'h07;
  logic [7:0] mk;
  int bad_count = 0;
  int comparisons = 0;
  always #5 mclk_i = ~mclk_i;
  stat_cmd stat_cmd_inst (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
    .hready_i(hready), .stb_i(stb), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .ist_o(ist), .config_o(cfg), .enables_o(ena), .error_o(err));
  ahb_host ahb_host_inst (.mclk_i(mclk_i), .hready_i(hready), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
    .hwdata_o(hwdata), .hung_o(hung));
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [31:0] ist_exp(input logic [7:0] m, input logic [7:0] v);
    return {31'h0, |(m & v)};
  endfunction
  task automatic summarize();
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb_host_inst.xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb_host_inst.xfer(1'b0, a, 32'h0, r);
    chk(r, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // recall needs two busy cycles, so every command waits three edges
  task automatic cmd(input logic [3:0] op, input logic [7:0] arg);
    wr(stat_pkg::ADDR_CMD, {16'h0000, arg, 4'h0, op});
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic pwr();
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask
  initial begin
    for (int k = 0; k < 20000 && hung !== 1'b1; k++) @(posedge mclk_i);
    bad_count++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    cmd(stat_pkg::OP_RESET, 8'h01);
    for (int i = 0; i < 10; i++) begin
      mk = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : s;
      s = nx(s);
      stb <= s;
      cmd(stat_pkg::OP_SET_POLL, mk);
      rd(stat_pkg::ADDR_PRE_MASK, {24'h000000, mk});
      rd(stat_pkg::ADDR_IST, ist_exp(mk, s));
      stb <= ~s;
      @(posedge mclk_i);
      rd(stat_pkg::ADDR_IST, ist_exp(mk, ~s));
      chk({31'h0, ist}, ist_exp(mk, ~s));
      rd(stat_pkg::ADDR_STATUS, {24'h000000, ~s});
      s = nx(s);
    end
    rd(8'h40, 32'h0);
    for (int f = 0; f < 2; f++) begin
      cmd(stat_pkg::OP_SET_PSC, f[7:0]);
      rd(stat_pkg::ADDR_PSC_FLAG, f);
    end
    wr(stat_pkg::ADDR_ERR, 32'h1);
    cmd(stat_pkg::OP_SET_PSC, 8'h02);
    rd(stat_pkg::ADDR_PSC_FLAG, 32'h1);
    chk({31'h0, err}, 32'h1);
    wr(stat_pkg::ADDR_CONFIG, 32'h00a5c3);
    cmd(stat_pkg::OP_SAVE, 8'h02);
    wr(stat_pkg::ADDR_CONFIG, 32'h00123e);
    cmd(stat_pkg::OP_RECALL, 8'h02);
    chk({8'h00, cfg}, 32'h00a5c3);
    wr(stat_pkg::ADDR_ERR, 32'h1);
    cmd(stat_pkg::OP_RECALL, 8'h03);
    chk({8'h00, cfg}, 32'h00a5c3);
    chk({31'h0, err}, 32'h1);
    rd(stat_pkg::ADDR_ERR, 32'h1);
    wr(stat_pkg::ADDR_ERR, 32'h1);
    cmd(stat_pkg::OP_RECALL, 8'h05);
    chk({31'h0, err}, 32'h1);
    cmd(stat_pkg::OP_RECALL, 8'h00);
    chk({8'h00, cfg}, {8'h00, stat_pkg::FACTORY_CFG});
    cmd(stat_pkg::OP_RECALL, 8'h02);
    cmd(stat_pkg::OP_RESET, 8'h00);
    chk({8'h00, cfg}, {8'h00, stat_pkg::FACTORY_CFG});
    cmd(stat_pkg::OP_RECALL, 8'h02);
    chk({8'h00, cfg}, 32'h00a5c3);
    wr(stat_pkg::ADDR_ENABLES, {16'h0000, s, nx(s)});
    cmd(stat_pkg::OP_SET_PSC, 8'h00);
    pwr();
    chk({16'h0000, ena}, {16'h0000, s, nx(s)});
    rd(stat_pkg::ADDR_PSC_FLAG, 32'h0);
    cmd(stat_pkg::OP_SET_PSC, 8'h01);
    pwr();
    chk({16'h0000, ena}, 32'h0);
    summarize();
  end
endmodule
